/* rtl/amr_regs.sv */
// Accessory mode register group: debug, scratch, routing, ID interrupts, measurement
// Assumes reg_req comes from the ULPI register decoder, one access per cycle
`timescale 1ns/100ps
module amr_regs #(
  parameter int MEASURE_CYC = amr_pkg::MEASURE_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire amr_pkg::amr_req_t reg_req,
  output logic [7:0]             reg_rdata,
  input  wire logic [1:0]        line_state,
  input  wire logic              accessory_mode_bit,
  input  wire logic              ulpi_data0_in,
  output logic                   ulpi_data1_out,
  input  wire logic              dp_in,
  input  wire logic              dm_in,
  output logic                   dm_out,
  output logic                   dm_oe,
  output logic                   left_audio_pin,
  output logic                   left_audio_connect,
  output logic                   right_mic_audio_pin,
  output logic                   right_mic_connect,
  output logic                   se_receiver_enable,
  output logic                   id_pin_ground_drive,
  input  wire logic              id_open_in,
  input  wire logic [2:0]        id_resistance_code_in,
  output logic                   alt_int
);

  amr_pkg::amr_wr_kind_t kind_scratch;
  amr_pkg::amr_wr_kind_t kind_ctrl;
  amr_pkg::amr_wr_kind_t kind_ien;
  amr_pkg::amr_wr_kind_t kind_vnd;
  logic [7:0]            scratch_reg;
  logic [7:0]            ctrl_reg;
  logic [7:0]            ien_reg;
  logic [7:0]            vnd_reg;
  logic [7:0]            vnd_hw_clr;
  logic [2:0]            code_reg;
  logic                  done_reg;
  logic                  id_open_prev_reg;
  logic                  done_pulse;
  logic                  vendor_read;
  logic                  audio_any;
  logic [7:0]            rd_next;

  function automatic amr_pkg::amr_wr_kind_t decode(input amr_pkg::amr_req_t r,
                                                   input logic [5:0] base);
    if (!r.we)
      decode = amr_pkg::AMR_WR_NONE;
    else if (r.addr == base)
      decode = amr_pkg::AMR_WR_WRITE;
    else if (r.addr == base + amr_pkg::OFS_SET)
      decode = amr_pkg::AMR_WR_SET;
    else if (r.addr == base + amr_pkg::OFS_CLR)
      decode = amr_pkg::AMR_WR_CLEAR;
    else
      decode = amr_pkg::AMR_WR_NONE;
  endfunction

  assign kind_scratch = decode(reg_req, amr_pkg::OFS_SCRATCH);
  assign kind_ctrl    = decode(reg_req, amr_pkg::OFS_CTRL);
  assign kind_ien     = decode(reg_req, amr_pkg::OFS_IRQ_EN);
  assign kind_vnd     = decode(reg_req, amr_pkg::OFS_VENDOR);

  // RULE2 scratch byte
  amr_wsc_reg #(.MASK(amr_pkg::MASK_SCRATCH), .RESET(amr_pkg::RESET_ZERO)) u_scratch (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ce        (ce),
    .kind      (kind_scratch),
    .wdata     (reg_req.wdata),
    .hw_clr    (8'h00),
    .value_reg (scratch_reg)
  );

  // RULE24 control reserved bits
  amr_wsc_reg #(.MASK(amr_pkg::MASK_CTRL), .RESET(amr_pkg::RESET_ZERO)) u_ctrl (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ce        (ce),
    .kind      (kind_ctrl),
    .wdata     (reg_req.wdata),
    .hw_clr    (8'h00),
    .value_reg (ctrl_reg)
  );

  // RULE18 enable unimplemented bits
  amr_wsc_reg #(.MASK(amr_pkg::MASK_IRQ_EN), .RESET(amr_pkg::RESET_ZERO)) u_ien (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ce        (ce),
    .kind      (kind_ien),
    .wdata     (reg_req.wdata),
    .hw_clr    (8'h00),
    .value_reg (ien_reg)
  );

  // RULE23 start self clear
  assign vnd_hw_clr = done_pulse ? (8'h01 << amr_pkg::VND_GO) : 8'h00;

  amr_wsc_reg #(.MASK(amr_pkg::MASK_VENDOR), .RESET(amr_pkg::RESET_ZERO)) u_vnd (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ce        (ce),
    .kind      (kind_vnd),
    .wdata     (reg_req.wdata),
    .hw_clr    (vnd_hw_clr),
    .value_reg (vnd_reg)
  );

  amr_measure #(.MEASURE_CYC(MEASURE_CYC)) u_measure (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .ce         (ce),
    .go         (vnd_reg[amr_pkg::VND_GO]),
    .done_pulse (done_pulse)
  );

  assign vendor_read = reg_req.re && (reg_req.addr >= amr_pkg::OFS_VENDOR)
                       && (reg_req.addr <= amr_pkg::OFS_VENDOR + amr_pkg::OFS_CLR);

  // RULE20 capture resistance code
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      code_reg <= 3'h0;
    else if (ce && done_pulse)
      code_reg <= id_resistance_code_in;
  end

  // RULE22 done clears on vendor read
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      done_reg <= 1'b0;
    else if (ce)
    begin
      if (done_pulse)
        done_reg <= 1'b1;
      else if (vendor_read)
        done_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      id_open_prev_reg <= 1'b0;
    else if (ce)
      id_open_prev_reg <= id_open_in;
  end

  // RULE14 RULE15 RULE17 alt interrupt
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      alt_int <= 1'b0;
    else if (ce)
      alt_int <= (ien_reg[amr_pkg::IEN_RISE] && id_open_in && !id_open_prev_reg)
              || (ien_reg[amr_pkg::IEN_FALL] && !id_open_in && id_open_prev_reg)
              || (done_pulse && !done_reg
                  && (ien_reg[amr_pkg::IEN_DONE] || vnd_reg[amr_pkg::VND_IEN]));
  end

  // RULE1 RULE19 RULE20 read mux
  always_comb
  begin
    rd_next = 8'h00;
    case (reg_req.addr)
      amr_pkg::OFS_DEBUG:
        rd_next = {6'h00, line_state} & amr_pkg::MASK_DEBUG;
      amr_pkg::OFS_SCRATCH, amr_pkg::OFS_SCRATCH + amr_pkg::OFS_SET,
      amr_pkg::OFS_SCRATCH + amr_pkg::OFS_CLR:
        rd_next = scratch_reg;
      amr_pkg::OFS_CTRL, amr_pkg::OFS_CTRL + amr_pkg::OFS_SET,
      amr_pkg::OFS_CTRL + amr_pkg::OFS_CLR:
        rd_next = ctrl_reg;
      amr_pkg::OFS_IRQ_EN, amr_pkg::OFS_IRQ_EN + amr_pkg::OFS_SET,
      amr_pkg::OFS_IRQ_EN + amr_pkg::OFS_CLR:
        rd_next = ien_reg;
      amr_pkg::OFS_STATUS:
        rd_next = {1'b0, done_reg, code_reg, 2'b00, id_open_in};
      amr_pkg::OFS_VENDOR, amr_pkg::OFS_VENDOR + amr_pkg::OFS_SET,
      amr_pkg::OFS_VENDOR + amr_pkg::OFS_CLR:
        rd_next = {vnd_reg[7:4], done_reg, code_reg};
      default:
        rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (ce && reg_req.re)
      reg_rdata <= rd_next;
  end

  assign audio_any = ctrl_reg[amr_pkg::CTRL_LEFT] || ctrl_reg[amr_pkg::CTRL_RIGHT]
                     || ctrl_reg[amr_pkg::CTRL_MIC];

  // RULE13 receivers off
  assign se_receiver_enable = !audio_any;
  // RULE8 ID ground
  assign id_pin_ground_drive = ctrl_reg[amr_pkg::CTRL_ID_GND];
  // RULE9 left switch
  assign left_audio_connect = ctrl_reg[amr_pkg::CTRL_LEFT];
  // RULE10 right or mic
  assign right_mic_connect = ctrl_reg[amr_pkg::CTRL_RIGHT] || ctrl_reg[amr_pkg::CTRL_MIC];

  // RULE4 RULE6 RULE7 RULE5 RULE11 routing
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dm_out              <= 1'b0;
      dm_oe               <= 1'b0;
      ulpi_data1_out      <= 1'b1;
      left_audio_pin      <= 1'b0;
      right_mic_audio_pin <= 1'b0;
    end
    else if (ce)
    begin
      dm_oe          <= accessory_mode_bit && ctrl_reg[amr_pkg::CTRL_TX_ROUTE];
      dm_out         <= ulpi_data0_in;
      ulpi_data1_out <= (accessory_mode_bit && ctrl_reg[amr_pkg::CTRL_RX_ROUTE]) ? dp_in : 1'b1;
      left_audio_pin <= ctrl_reg[amr_pkg::CTRL_LEFT]
                        && ((accessory_mode_bit && ctrl_reg[amr_pkg::CTRL_TX_ROUTE])
                            ? ulpi_data0_in : dm_in);
      right_mic_audio_pin <= right_mic_connect && dp_in;
    end
  end

  sequence s_measure_end;
    done_pulse ##1 !vnd_reg[amr_pkg::VND_GO];
  endsequence

  a_debug_read_zero: assert property (@(posedge sys_clk) disable iff (rst) // RULE1
    ce && reg_req.re && reg_req.addr == amr_pkg::OFS_DEBUG
    |=> reg_rdata == {6'h00, $past(line_state)})
    else $error("debug read wrong");

  a_scratch_isolated: assert property (@(posedge sys_clk) disable iff (rst) // RULE2
    ce && kind_scratch != amr_pkg::AMR_WR_NONE |=> $stable(ctrl_reg) && $stable(ien_reg))
    else $error("scratch write disturbed other state");

  a_data1_held_high: assert property (@(posedge sys_clk) disable iff (rst) // RULE5
    ce && !ctrl_reg[amr_pkg::CTRL_RX_ROUTE] |=> ulpi_data1_out)
    else $error("data1 not held high");

  a_receiver_audio_off: assert property (@(posedge sys_clk) disable iff (rst) // RULE13
    (ctrl_reg[6:4] != 3'b000) |-> !se_receiver_enable)
    else $error("receivers enabled with audio switch");

  a_go_self_clear: assert property (@(posedge sys_clk) disable iff (rst) // RULE23
    ce && done_pulse && kind_vnd == amr_pkg::AMR_WR_NONE |-> s_measure_end)
    else $error("start bit not cleared at end");

  a_done_sticky: assert property (@(posedge sys_clk) disable iff (rst) // RULE22
    done_reg && ce && !vendor_read |=> done_reg)
    else $error("done cleared without vendor read");

  a_rise_alt_int: assert property (@(posedge sys_clk) disable iff (rst) // RULE14
    ce && ien_reg[0] && id_open_in && !id_open_prev_reg |=> alt_int)
    else $error("rising float interrupt missing");

  a_fall_alt_int: assert property (@(posedge sys_clk) disable iff (rst) // RULE15
    ce && ien_reg[1] && !id_open_in && id_open_prev_reg |=> alt_int)
    else $error("falling float interrupt missing");

  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (rst) // RULE24
    ctrl_reg[7] == 1'b0 && ctrl_reg[0] == 1'b0 && ien_reg[7:6] == 2'b00 && ien_reg[4:2] == 3'b000)
    else $error("reserved bit set");

  a_done_alt_int: assert property (@(posedge sys_clk) disable iff (rst) // RULE17
    ce && done_pulse && !done_reg
    && (ien_reg[amr_pkg::IEN_DONE] || vnd_reg[amr_pkg::VND_IEN]) |=> alt_int)
    else $error("measurement interrupt missing");

  a_done_code_latch: assert property (@(posedge sys_clk) disable iff (rst) // RULE20 RULE21
    ce && done_pulse |=> done_reg && code_reg == $past(id_resistance_code_in))
    else $error("done or code not captured");

  a_tx_route_dm: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
    ce && accessory_mode_bit && ctrl_reg[amr_pkg::CTRL_TX_ROUTE]
    |=> dm_oe && dm_out == $past(ulpi_data0_in))
    else $error("transmit route not on DM");

  a_rx_route_dp: assert property (@(posedge sys_clk) disable iff (rst) // RULE7
    ce && accessory_mode_bit && ctrl_reg[amr_pkg::CTRL_RX_ROUTE]
    |=> ulpi_data1_out == $past(dp_in))
    else $error("receive route not on data1");

  a_left_switch_dm: assert property (@(posedge sys_clk) disable iff (rst) // RULE9
    ce && ctrl_reg[amr_pkg::CTRL_LEFT]
    && !(accessory_mode_bit && ctrl_reg[amr_pkg::CTRL_TX_ROUTE])
    |=> left_audio_pin == $past(dm_in))
    else $error("left switch not on DM");

  a_status_reserved: assert property (@(posedge sys_clk) disable iff (rst) // RULE18
    ce && reg_req.re && reg_req.addr == amr_pkg::OFS_STATUS
    |=> reg_rdata[7] == 1'b0 && reg_rdata[2:1] == 2'b00)
    else $error("status reserved bits set");

endmodule // amr_regs

/* pkg/amr_pkg.sv */
// Constants and carrier types for the accessory mode register group
// Assumes a ULPI front end that decodes register writes and reads into a simple strobe port
// How it works
// RULE1 - Debug register returns line state, upper zero
// RULE2 - Scratch byte, reset zero, no side effects
// RULE3 - Write replaces, set ORs, clear masks
// RULE4 - Link programs routes before accessory mode
// RULE5 - Data line 1 high while receive route off
// RULE6 - Bit 2 routes data 0 onto DM
// RULE7 - Bit 3 routes DP onto data 1
// RULE8 - Bit 1 drives ID pin to ground
// RULE9 - Bit 4 connects DM to left audio
// RULE10 - Bit 5 or 6 connects DP to right
// RULE11 - UART data also reaches enabled audio pins
// RULE12 - Link avoids UART routes during audio switching; the bench switches audio with routes set (8'h3c, 8'h54)
// RULE13 - Audio switches disable single-ended receivers
// RULE14 - ID floating rise raises alt interrupt
// RULE15 - ID floating fall raises alt interrupt
// RULE16 - Link enables ID pull-up before float interrupts
// RULE17 - Measure done interrupt, enable ORed vendor
// RULE18 - Unimplemented enable and status bits read zero
// RULE19 - Status bit 0 shows ID floating
// RULE20 - Status bits 5:3 hold resistance code
// RULE21 - Done bit sets after 282 us measurement
// RULE22 - Only vendor register read clears done
// RULE23 - Start bit measures, self clears at end
// RULE24 - Reserved control, enable, status bits read zero
package amr_pkg;

  localparam logic [5:0] OFS_DEBUG   = 6'h15;
  localparam logic [5:0] OFS_SCRATCH = 6'h16;
  localparam logic [5:0] OFS_CTRL    = 6'h19;
  localparam logic [5:0] OFS_IRQ_EN  = 6'h1d;
  localparam logic [5:0] OFS_STATUS  = 6'h20;
  localparam logic [5:0] OFS_VENDOR  = 6'h36;
  localparam logic [5:0] OFS_SET     = 6'h01;
  localparam logic [5:0] OFS_CLR     = 6'h02;

  localparam int CTRL_ID_GND   = 1;
  localparam int CTRL_TX_ROUTE = 2;
  localparam int CTRL_RX_ROUTE = 3;
  localparam int CTRL_LEFT     = 4;
  localparam int CTRL_RIGHT    = 5;
  localparam int CTRL_MIC      = 6;
  localparam int IEN_RISE      = 0;
  localparam int IEN_FALL      = 1;
  localparam int IEN_DONE      = 5;
  localparam int ST_OPEN       = 0;
  localparam int ST_CODE_LO    = 3;
  localparam int ST_DONE       = 6;
  localparam int VND_DONE      = 3;
  localparam int VND_GO        = 4;
  localparam int VND_IEN       = 6;

  localparam logic [7:0] MASK_DEBUG   = 8'h03;
  localparam logic [7:0] MASK_SCRATCH = 8'hff;
  localparam logic [7:0] MASK_CTRL    = 8'h7e;
  localparam logic [7:0] MASK_IRQ_EN  = 8'h23;
  localparam logic [7:0] MASK_VENDOR  = 8'h70;
  localparam logic [7:0] RESET_ZERO   = 8'h00;

  localparam int CLK_HZ       = 20000000;
  localparam int MEASURE_US   = 282;
  localparam int MEASURE_CYC  = (MEASURE_US * (CLK_HZ / 1000000));

  typedef enum logic [1:0] {
    AMR_WR_NONE  = 2'b00,
    AMR_WR_WRITE = 2'b01,
    AMR_WR_SET   = 2'b10,
    AMR_WR_CLEAR = 2'b11
  } amr_wr_kind_t;

  typedef struct packed {
    logic       we;
    logic       re;
    logic [5:0] addr;
    logic [7:0] wdata;
  } amr_req_t;

endpackage

/* rtl/amr_wsc_reg.sv */
// One register byte with write, set and clear access
// Assumes access kind is already decoded from the address
`timescale 1ns/100ps
module amr_wsc_reg #(
  parameter logic [7:0] MASK  = 8'hff,
  parameter logic [7:0] RESET = 8'h00
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire amr_pkg::amr_wr_kind_t kind,
  input  wire logic [7:0]            wdata,
  input  wire logic [7:0]            hw_clr,
  output logic [7:0]                 value_reg
);

  logic [7:0] value_next;

  // RULE3 write set clear
  always_comb
  begin
    case (kind)
      amr_pkg::AMR_WR_WRITE: value_next = wdata;
      amr_pkg::AMR_WR_SET:   value_next = value_reg | wdata;
      amr_pkg::AMR_WR_CLEAR: value_next = value_reg & ~wdata;
      default:               value_next = value_reg;
    endcase
    value_next = value_next & ~hw_clr & MASK;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      value_reg <= RESET & MASK;
    else if (ce)
      value_reg <= value_next;
  end

endmodule // amr_wsc_reg

/* rtl/amr_measure.sv */
// Resistance measurement timer
// Assumes the analog converter result is valid when done pulses
`timescale 1ns/100ps
module amr_measure #(
  parameter int MEASURE_CYC = amr_pkg::MEASURE_CYC
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic go,
  output logic      done_pulse
);

  logic [15:0] count_reg;

  // RULE21 measurement time
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      count_reg <= 16'h0000;
    else if (ce)
    begin
      if (!go || done_pulse)
        count_reg <= 16'h0000;
      else
        count_reg <= count_reg + 16'h0001;
    end
  end

  assign done_pulse = go && (count_reg == 16'(MEASURE_CYC - 1));

endmodule // amr_measure

/* tb/amr_link_model.sv */
// Link controller model: register writes and reads, accessory mode level
// Assumes the register port answers one cycle after a read strobe
`timescale 1ns/100ps
module amr_link_model (
  input  wire logic         sys_clk,
  input  wire logic [7:0]   reg_rdata,
  output amr_pkg::amr_req_t reg_req,
  output logic              accessory_mode_bit
);
  initial
  begin
    reg_req = '0;
    accessory_mode_bit = 1'b0;
  end

  // One strobe cycle, then released lines show inverted values
  task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d);
  begin
    @(posedge sys_clk);
    reg_req <= '{we: w, re: !w, addr: a, wdata: d};
    @(posedge sys_clk);
    reg_req <= '{we: 1'b0, re: 1'b0, addr: ~a, wdata: ~d};
  end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
  begin
    access(1'b1, a, d);
  end
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
  begin
    access(1'b0, a, 8'h00);
    @(posedge sys_clk);
    d = reg_rdata;
  end
  endtask

  // routes first with audio off, then mode
  task automatic uart_enter(input logic [7:0] routes);
  begin
    wr(amr_pkg::OFS_CTRL, routes & 8'h0c);
    @(posedge sys_clk);
    accessory_mode_bit <= 1'b1;
  end
  endtask
endmodule // amr_link_model

/* tb/testbench.sv */
// Self-checking bench for the accessory mode register group
// Assumes the link model owns the register port; pins are driven here
`timescale 1ns/100ps
module testbench;
  localparam int     MC = 8;
  logic              sys_clk;
  logic              rst;
  logic              ce;
  logic [1:0]        line_state;
  logic              ulpi_data0_in;
  logic              dp_in;
  logic              dm_in;
  logic              id_open_in;
  logic [2:0]        id_code;
  logic [7:0]        reg_rdata;
  logic              mode;
  logic              data1_out;
  logic              dm_out;
  logic              dm_oe;
  logic              left_pin;
  logic              right_pin;
  logic              left_con;
  logic              right_con;
  logic              se_en;
  logic              id_gnd;
  logic              alt_int;
  amr_pkg::amr_req_t reg_req;
  int                miscompares;
  int                check_count;
  int                n;
  int                k;
  int                v;
  int                got;
  int                q [3];
  logic [7:0]        c;
  logic [7:0]        d;
  logic [5:0]        base [3] = '{amr_pkg::OFS_SCRATCH, amr_pkg::OFS_CTRL, amr_pkg::OFS_IRQ_EN};
  logic [7:0]        msk [3] = '{amr_pkg::MASK_SCRATCH, amr_pkg::MASK_CTRL, amr_pkg::MASK_IRQ_EN};
  logic [5:0]        ofs [6] = '{amr_pkg::OFS_DEBUG, amr_pkg::OFS_SCRATCH, amr_pkg::OFS_CTRL,
                                 amr_pkg::OFS_IRQ_EN, amr_pkg::OFS_STATUS, 6'h3f};
  logic [7:0]        ph [3] = '{8'h0c, 8'h3c, 8'h54};

  amr_regs #(.MEASURE_CYC(MC)) DUT (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .line_state(line_state), .accessory_mode_bit(mode), .ulpi_data0_in(ulpi_data0_in),
    .ulpi_data1_out(data1_out), .dp_in(dp_in), .dm_in(dm_in), .dm_out(dm_out),
    .dm_oe(dm_oe), .left_audio_pin(left_pin), .left_audio_connect(left_con),
    .right_mic_audio_pin(right_pin), .right_mic_connect(right_con),
    .se_receiver_enable(se_en), .id_pin_ground_drive(id_gnd), .id_open_in(id_open_in),
    .id_resistance_code_in(id_code), .alt_int(alt_int));

  amr_link_model link (
    .sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_req(reg_req), .accessory_mode_bit(mode));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic end_sim();
  begin
    $display("Comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask

  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
  begin
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  end
  endtask

  task automatic chk_pin(input logic g, input logic e);
  begin
    chk_reg({7'h00, g}, {7'h00, e});
  end
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
  begin
    link.rd(a, d);
    chk_reg(d, e);
  end
  endtask

  // Wait for the measurement interrupt, bounded
  task automatic wait_alt();
  begin
    got = 0;
    while (alt_int !== 1'b1 && got < 40)
    begin
      @(posedge sys_clk);
      got++;
    end
    if (got >= 40)
    begin
      miscompares++;
      end_sim();
    end
  end
  endtask

  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    line_state = 2'h0;
    ulpi_data0_in = 1'b0;
    dp_in = 1'b0;
    dm_in = 1'b0;
    id_open_in = 1'b0;
    id_code = 3'h0;
    miscompares = 0;
    check_count = 0;
    q = '{0, 0, 0};
    void'($urandom(67));
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (ofs[i])
      rd_chk(ofs[i], 8'h00);
    for (n = 0; n < 4; n++)
    begin
      @(posedge sys_clk);
      line_state <= n[1:0];
      rd_chk(amr_pkg::OFS_DEBUG, {6'h00, n[1:0]});
    end
    for (n = 0; n < 36; n++)
    begin
      k = (n / 3) % 3;
      v = $urandom_range(255) & ((n % 3 == 1) ? 'hf3 : 'hff);
      link.wr(base[n % 3] + k[5:0], v[7:0]);
      dm_in <= 1'($urandom_range(1));
      dp_in <= 1'($urandom_range(1));
      q[n % 3] = (k == 0) ? v : (k == 1) ? (q[n % 3] | v) : (q[n % 3] & ~v);
      q[n % 3] = q[n % 3] & int'(msk[n % 3]);
      rd_chk(base[n % 3] + 6'(2 - k), q[n % 3][7:0]);
      chk_pin(id_gnd, q[1][1]);
      chk_pin(left_con, q[1][4]);
      chk_pin(right_con, q[1][5] | q[1][6]);
      chk_pin(se_en, q[1][6:4] == 0);
      chk_pin(data1_out, 1'b1);
      chk_pin(left_pin, q[1][4] & dm_in);
      chk_pin(right_pin, (q[1][5] | q[1][6]) & dp_in);
      chk_pin(dm_oe, 1'b0);
    end
    // Clock enable low drops a write
    ce <= 1'b0;
    link.wr(amr_pkg::OFS_SCRATCH, ~q[0][7:0]);
    ce <= 1'b1;
    rd_chk(amr_pkg::OFS_SCRATCH, q[0][7:0]);
    link.uart_enter(8'h0c);
    for (n = 0; n < 12; n++)
    begin
      c = ph[n / 4];
      link.wr(amr_pkg::OFS_CTRL, c);
      ulpi_data0_in <= 1'($urandom_range(1));
      dp_in <= 1'($urandom_range(1));
      dm_in <= 1'($urandom_range(1));
      repeat (2) @(posedge sys_clk);
      chk_pin(dm_out, ulpi_data0_in);
      chk_pin(dm_oe, 1'b1);
      chk_pin(data1_out, c[3] ? dp_in : 1'b1);
      chk_pin(left_pin, c[4] & ulpi_data0_in);
      chk_pin(right_pin, (c[5] | c[6]) & dp_in);
      rd_chk(amr_pkg::OFS_CTRL, c);
    end
    // pull-up assumed on while the floating level is driven
    for (n = 1; n < 3; n++)
    begin
      link.wr(amr_pkg::OFS_IRQ_EN, n[7:0]);
      for (k = 0; k < 2; k++)
      begin
        @(posedge sys_clk);
        id_open_in <= !id_open_in;
        got = 0;
        repeat (4) @(posedge sys_clk) got += alt_int;
        chk_reg(got[7:0], {7'h00, (k == 0) ? n[0] : n[1]});
        rd_chk(amr_pkg::OFS_STATUS, {7'h00, id_open_in});
      end
    end
    for (n = 0; n < 2; n++)
    begin
      @(posedge sys_clk);
      v = $urandom_range(6);
      id_code <= (v == 6) ? 3'h7 : 3'(v);
      link.wr(amr_pkg::OFS_IRQ_EN, (n == 0) ? 8'h20 : 8'h00);
      link.wr(amr_pkg::OFS_VENDOR + n[5:0], (n == 0) ? 8'h10 : 8'h50);
      wait_alt();
      chk_pin(got >= MC && got <= MC + 4, 1'b1);
      rd_chk(amr_pkg::OFS_STATUS, {2'b01, id_code, 3'h0});
      rd_chk(amr_pkg::OFS_STATUS, {2'b01, id_code, 3'h0});
      rd_chk(amr_pkg::OFS_VENDOR, {1'b0, n[0], 3'b001, id_code});
      rd_chk(amr_pkg::OFS_STATUS, {2'b00, id_code, 3'h0});
    end
    end_sim();
  end
endmodule // testbench
